// *** pim_mapper.sv ***
// Purpose: process image mapper for digital output, combined and analog input modules
// Assumes: field inputs are asynchronous; register port is on I_CLK_SYS
// Notes:   image refresh is periodic or forced; reads of the image see the last refresh
`timescale 1ns/100ps
`default_nettype none

module pim_mapper #(
  parameter int UPDATE_CYC = pim_pkg::UPDATE_CYC
) (
  // clock and reset
  input  wire logic                          I_CLK_SYS,
  input  wire logic                          I_RESET_N,
  // register port
  input  wire logic [pim_pkg::ADDR_W-1:0]    I_ADDR,
  input  wire logic [pim_pkg::DATA_W-1:0]    I_WDATA,
  input  wire logic                          I_WR,
  input  wire logic                          I_RD,
  output logic      [pim_pkg::DATA_W-1:0]    O_RDATA,
  output logic                               O_IRQ,
  // field side: diagnostic output module
  input  wire pim_pkg::pim_fault_s           I_FAULT,
  output logic      [7:0]                    O_DO8_DIAG,
  // field side: sixteen-channel output module
  output logic      [15:0]                   O_DO16,
  // field side: combined input/output module
  input  wire logic [7:0]                    I_DIGITAL_INPUT_CHANNEL,
  output logic      [7:0]                    O_DO8_COMB,
  // field side: analog inputs, 0/1 one-channel, 2/3 two-channel module
  input  wire pim_pkg::pim_ai_s [pim_pkg::NUM_AI-1:0] I_AI,
  output logic      [pim_pkg::NUM_AI-1:0][7:0]        O_AI_CFG
);

  // ****************************************************************
  // state
  // ****************************************************************
  pim_pkg::pim_state_s r;
  pim_pkg::pim_state_s n;

  // present fault condition per channel, after synchronising
  logic [7:0] fault_now;
  assign fault_now = r.fault_s2.overload | r.fault_s2.short_circuit
                   | r.fault_s2.broken_wire;

  logic wr_ctrl;
  assign wr_ctrl = I_WR && (I_ADDR == pim_pkg::ADR_CTRL);

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    logic             upd_now;
    logic [pim_pkg::IRQ_W-1:0] set_ev;
    logic [pim_pkg::IRQ_W-1:0] clr_ev;
    upd_now = 1'b0;
    set_ev  = '0;
    clr_ev  = '0;
    n       = r;

    // two-stage synchronisers; first stage feeds only the second
    n.fault_s1 = I_FAULT;
    n.fault_s2 = r.fault_s1;
    n.din_s1   = I_DIGITAL_INPUT_CHANNEL;
    n.din_s2   = r.din_s1;
    n.ai_s1    = I_AI;
    n.ai_s2    = r.ai_s1;

    // refresh divider; a forced refresh restarts the period
    if (r.run) begin
      if (r.tick == 16'(UPDATE_CYC - 1)) begin
        n.tick  = '0;
        upd_now = 1'b1;
      end else begin
        n.tick = r.tick + 16'h0001;
      end
    end else begin
      n.tick = '0;
    end
    if (wr_ctrl && I_WDATA[pim_pkg::CTRL_FORCE]) begin
      n.tick  = '0;
      upd_now = 1'b1;
    end
    n.upd = upd_now;

    // image capture
    if (upd_now) begin
      n.diag = fault_now;
      n.din  = r.din_s2;
      for (int i = 0; i < pim_pkg::NUM_AI; i++) begin
        n.ai_word[i] = {r.ai_s2[i].d_hi, r.ai_s2[i].d_lo};
        n.ai_stat[i] = r.ai_s2[i].ctrl_stat;
      end
      set_ev[pim_pkg::IRQ_FAULT] = |(fault_now & ~r.diag);
      set_ev[pim_pkg::IRQ_DIN]   = (r.din_s2 != r.din);
      set_ev[pim_pkg::IRQ_UPD]   = 1'b1;
    end

    // register writes
    if (I_WR) begin
      case (I_ADDR)
        pim_pkg::ADR_DO8D:     n.do8d = I_WDATA[7:0];
        pim_pkg::ADR_DO16:     n.do16 = I_WDATA;
        pim_pkg::ADR_DO8C:     n.do8c = I_WDATA[7:0];
        pim_pkg::ADR_IRQ_MASK: n.mask = I_WDATA[pim_pkg::IRQ_W-1:0];
        pim_pkg::ADR_CTRL:     n.run  = I_WDATA[pim_pkg::CTRL_RUN];
        default: begin
          if (I_ADDR[7:2] == pim_pkg::ADR_AI_CFG0[7:2]) begin
            n.ai_cfg[I_ADDR[1:0]] = I_WDATA[7:0];
          end
        end
      endcase
    end

    // register reads; data stands one cycle, zero otherwise
    n.rdata = '0;
    if (I_RD) begin
      case (I_ADDR)
        pim_pkg::ADR_AI_MEAS:  n.rdata = r.ai_word[0];
        pim_pkg::ADR_AI_REF:   n.rdata = r.ai_word[1];
        pim_pkg::ADR_AI2_CH1:  n.rdata = r.ai_word[2];
        pim_pkg::ADR_AI2_CH2:  n.rdata = r.ai_word[3];
        pim_pkg::ADR_DIAG:     n.rdata = {8'h00, r.diag};
        pim_pkg::ADR_DIN:      n.rdata = {8'h00, r.din};
        pim_pkg::ADR_DO8D:     n.rdata = {8'h00, r.do8d};
        pim_pkg::ADR_DO16:     n.rdata = r.do16;
        pim_pkg::ADR_DO8C:     n.rdata = {8'h00, r.do8c};
        pim_pkg::ADR_IRQ_STAT: begin
          n.rdata = {13'h0000, r.stat};
          clr_ev  = r.stat;
        end
        pim_pkg::ADR_IRQ_MASK: n.rdata = {13'h0000, r.mask};
        pim_pkg::ADR_CTRL:     n.rdata = {15'h0000, r.run};
        default: begin
          if (I_ADDR[7:2] == pim_pkg::ADR_AI_CFG0[7:2]) begin
            // status byte returned in the upper byte of the configuration read, kept out of the image words
            n.rdata = {r.ai_stat[I_ADDR[1:0]], r.ai_cfg[I_ADDR[1:0]]};
          end
        end
      endcase
    end

    // sticky status: an event in the clearing read's cycle survives
    n.stat = (r.stat & ~clr_ev) | set_ev;
    n.irq  = |(n.stat & n.mask);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      r          <= '0;
      r.run      <= pim_pkg::RST_RUN;
      r.mask     <= pim_pkg::RST_MASK;
      r.do16     <= pim_pkg::RST_WORD;
      r.do8d     <= pim_pkg::RST_BYTE;
      r.do8c     <= pim_pkg::RST_BYTE;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign O_RDATA    = r.rdata;
  assign O_IRQ      = r.irq;
  assign O_DO8_DIAG = r.do8d;
  assign O_DO16     = r.do16;
  assign O_DO8_COMB = r.do8c;
  assign O_AI_CFG   = r.ai_cfg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);

  sequence s_refresh;
    r.upd;
  endsequence

  sequence s_read(logic [7:0] a);
    I_RD && !I_WR && (I_ADDR == a);
  endsequence

  sequence s_new_fault;
    r.upd && ((r.diag & ~$past(r.diag)) != 8'h00);
  endsequence

  // flags equal the present condition at a refresh
  AST_FLAG_SET: assert property (
    s_refresh |-> r.diag == $past(fault_now))
    else $error("fault flags differ from channel condition");

  // a flag with no fault behind it reads zero
  AST_FLAG_CLEAR: assert property (
    s_refresh |-> (r.diag & ~$past(fault_now)) == 8'h00)
    else $error("fault flag set without a fault");

  // refresh of a vanished fault drops its flag and keeps it low
  AST_FLAG_FOLLOW: assert property (
    s_refresh ##0 (r.diag == 8'h00) ##1 (!r.upd)[*2] |-> r.diag == 8'h00)
    else $error("fault flag changed between refreshes");

  // fault flags read back in low byte bit order
  AST_DIAG_READ: assert property (
    s_read(pim_pkg::ADR_DIAG) |=> O_RDATA == {8'h00, $past(r.diag)})
    else $error("fault flag image read wrong");

  // sixteen-channel drives follow a write in one cycle
  AST_DO16: assert property (
    I_WR && I_ADDR == pim_pkg::ADR_DO16 |=> O_DO16 == $past(I_WDATA))
    else $error("sixteen-channel drive not taken");

  // combined module drives and inputs
  AST_DO8C: assert property (
    I_WR && I_ADDR == pim_pkg::ADR_DO8C |=> O_DO8_COMB == $past(I_WDATA[7:0]))
    else $error("combined drive not taken");

  AST_DIN_CAPTURE: assert property (
    s_refresh |-> r.din == $past(r.din_s2))
    else $error("combined inputs not captured");

  // analog value word built low byte first
  AST_AI_WORD: assert property (
    s_refresh |-> r.ai_word[2] == $past({r.ai_s2[2].d_hi, r.ai_s2[2].d_lo}))
    else $error("analog word byte order wrong");

  // control/status byte never enters an image word
  AST_AI_STAT_OUT: assert property (
    s_refresh |-> r.ai_stat[3] == $past(r.ai_s2[3].ctrl_stat))
    else $error("analog status byte not kept internal");

  // every offset below the digital data returns an analog word
  AST_AI_AHEAD: assert property (
    I_RD && !I_WR && I_ADDR < pim_pkg::ADR_DIAG
      |=> O_RDATA == $past(r.ai_word[I_ADDR[1:0]]))
    else $error("analog word not ahead of digital data");

  // reference word at offset 1
  AST_AI_REF: assert property (
    s_read(pim_pkg::ADR_AI_REF) |=> O_RDATA == $past(r.ai_word[1]))
    else $error("reference word misplaced");

  // two-channel module, channel 2 at offset 1 of its pair
  AST_AI2_CH2: assert property (
    s_read(pim_pkg::ADR_AI2_CH2) |=> O_RDATA == $past(r.ai_word[3]))
    else $error("two-channel word misplaced");

  // a rising flag with fault interrupt unmasked has the line high at that refresh
  AST_IRQ_FAULT: assert property (
    s_new_fault ##0 r.mask[pim_pkg::IRQ_FAULT] |-> O_IRQ)
    else $error("fault interrupt missing");

  // reading status with no refresh in the same cycle clears it
  AST_STAT_CLR: assert property (
    s_read(pim_pkg::ADR_IRQ_STAT) ##0 !n.upd |=> r.stat == 3'h0)
    else $error("status not cleared by read");

  // a forced refresh happens in the next cycle
  AST_FORCE: assert property (
    wr_ctrl && I_WDATA[pim_pkg::CTRL_FORCE] |=> r.upd)
    else $error("forced refresh missing");

  // ****************************************************************
  // refresh timing, status and register side
  // ****************************************************************

  // the divider fires a refresh at the end of each period
  AST_PERIOD: assert property (
    r.run && (r.tick == 16'(UPDATE_CYC - 1)) |=> r.upd)
    else $error("periodic refresh missing");

  // with the divider stopped only a forced refresh updates the image
  AST_RUN_OFF: assert property (
    !r.run && !(wr_ctrl && I_WDATA[pim_pkg::CTRL_FORCE]) |=> !r.upd)
    else $error("refresh while stopped");

  // image words hold between refreshes; field changes stay invisible
  AST_IMAGE_HOLD: assert property (
    !r.upd |-> $stable(r.diag) && $stable(r.din) && $stable(r.ai_word))
    else $error("image changed between refreshes");

  // reference word taken at every refresh, lower byte as low byte
  AST_AI_REF_CAPTURE: assert property (
    s_refresh |-> r.ai_word[1] == $past({r.ai_s2[1].d_hi, r.ai_s2[1].d_lo}))
    else $error("reference word not captured");

  // read data stand one cycle only, zero otherwise
  AST_RDATA_IDLE: assert property (
    !I_RD |=> O_RDATA == 16'h0000)
    else $error("read data outside a read");

  // diagnostic module drives follow a write in one cycle
  AST_DO8D: assert property (
    I_WR && I_ADDR == pim_pkg::ADR_DO8D |=> O_DO8_DIAG == $past(I_WDATA[7:0]))
    else $error("diagnostic module drive not taken");

  // drives stand until rewritten
  AST_DO16_HOLD: assert property (
    !(I_WR && I_ADDR == pim_pkg::ADR_DO16) |=> $stable(O_DO16))
    else $error("sixteen-channel drive changed without a write");

  // configuration byte lands in its own channel
  AST_CFG_WRITE: assert property (
    I_WR && I_ADDR == pim_pkg::ADR_AI_CFG0 |=> O_AI_CFG[0] == $past(I_WDATA[7:0]))
    else $error("configuration byte not taken");

  // mask write taken in one cycle
  AST_MASK_WRITE: assert property (
    I_WR && I_ADDR == pim_pkg::ADR_IRQ_MASK |=> r.mask == $past(I_WDATA[pim_pkg::IRQ_W-1:0]))
    else $error("mask write not taken");

  // every refresh reports itself in status
  AST_UPD_EVENT: assert property (
    s_refresh |-> r.stat[pim_pkg::IRQ_UPD])
    else $error("refresh status bit missing");

  // changed combined inputs raise their status bit
  AST_DIN_EVENT: assert property (
    s_refresh ##0 (r.din != $past(r.din)) |-> r.stat[pim_pkg::IRQ_DIN])
    else $error("input change status bit missing");

  // status bits stay set until a status read
  AST_STAT_STICKY: assert property (
    (r.stat != 3'h0) && !(I_RD && I_ADDR == pim_pkg::ADR_IRQ_STAT)
      |=> (r.stat & $past(r.stat)) == $past(r.stat))
    else $error("status bit lost without a read");

  // interrupt line high exactly while an unmasked status bit is set
  AST_IRQ_LEVEL: assert property (
    O_IRQ == (|(r.stat & r.mask)))
    else $error("interrupt line differs from masked status");

endmodule // pim_mapper

`default_nettype wire

// *** pim_pkg.sv ***
// Purpose: constants and types of the process image mapper
// Assumes: 16-bit register port, one 10 MHz clock
// Notes:   image word offsets and register offsets live here
//
// Contract
// - eight-channel diagnostic output module gives one fault flag per channel
// - fault flags sit in input image bits 0..7, drives in output image
// - flag reads 0 when channel is clean, 1 on overload, short, broken wire
// - output image bit n-1 drives channel n of the sixteen-channel module
// - combined module: inputs 1..8 in bits 0..7, outputs from bits 0..7
// - each analog channel supplies a 16-bit value and 8 control/status bits
// - control/status bits stay internal; only the value word enters the image (the mapper returns them in the upper byte of the 0x30..0x33 reads)
// - analog input words stand ahead of all digital input data
// - one-channel module: measured word at offset 0, reference word at 1
// - two-channel module: channel 1 word at offset 0, channel 2 at 1
`default_nettype none

package pim_pkg;

  // ****************************************************************
  // widths and timing
  // ****************************************************************
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 16;
  localparam int NUM_AI     = 4;
  localparam int CLK_MHZ    = 10;
  localparam int UPDATE_US  = 100;                 // image refresh period
  localparam int UPDATE_CYC = UPDATE_US * CLK_MHZ; // cycles per refresh

  // ****************************************************************
  // register offsets (input image first, analog ahead of digital)
  // ****************************************************************
  localparam logic [7:0] ADR_AI_MEAS  = 8'h00; // one-channel measured word
  localparam logic [7:0] ADR_AI_REF   = 8'h01; // one-channel reference word
  localparam logic [7:0] ADR_AI2_CH1  = 8'h02; // two-channel word, channel 1
  localparam logic [7:0] ADR_AI2_CH2  = 8'h03; // two-channel word, channel 2
  localparam logic [7:0] ADR_DIAG     = 8'h04; // fault flags
  localparam logic [7:0] ADR_DIN      = 8'h05; // combined module inputs
  localparam logic [7:0] ADR_DO8D     = 8'h10; // diagnostic module drives
  localparam logic [7:0] ADR_DO16     = 8'h11; // sixteen-channel drives
  localparam logic [7:0] ADR_DO8C     = 8'h12; // combined module drives
  localparam logic [7:0] ADR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h21;
  localparam logic [7:0] ADR_CTRL     = 8'h22;
  localparam logic [7:0] ADR_AI_CFG0  = 8'h30; // 0x30..0x33, one per channel

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int IRQ_FAULT = 0;  // a fault flag rose
  localparam int IRQ_DIN   = 1;  // combined inputs changed
  localparam int IRQ_UPD   = 2;  // image refreshed
  localparam int IRQ_W     = 3;
  localparam int CTRL_RUN   = 0; // periodic refresh enable
  localparam int CTRL_FORCE = 1; // write 1: refresh now
  localparam logic          RST_RUN  = 1'b1;
  localparam logic [2:0]    RST_MASK = 3'h0;
  localparam logic [15:0]   RST_WORD = 16'h0000;
  localparam logic [7:0]    RST_BYTE = 8'h00;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] overload;
    logic [7:0] short_circuit;
    logic [7:0] broken_wire;
  } pim_fault_s;

  typedef struct packed {
    logic [7:0] ctrl_stat; // control/status byte
    logic [7:0] d_hi;      // higher-numbered data byte
    logic [7:0] d_lo;      // lower-numbered data byte
  } pim_ai_s;

  typedef struct packed {
    pim_fault_s              fault_s1;
    pim_fault_s              fault_s2;
    logic [7:0]              din_s1;
    logic [7:0]              din_s2;
    pim_ai_s [NUM_AI-1:0]    ai_s1;
    pim_ai_s [NUM_AI-1:0]    ai_s2;
    logic [7:0]              diag;
    logic [7:0]              din;
    logic [NUM_AI-1:0][15:0] ai_word;
    logic [NUM_AI-1:0][7:0]  ai_stat;
    logic [NUM_AI-1:0][7:0]  ai_cfg;
    logic [7:0]              do8d;
    logic [15:0]             do16;
    logic [7:0]              do8c;
    logic                    run;
    logic [IRQ_W-1:0]        stat;
    logic [IRQ_W-1:0]        mask;
    logic                    irq;
    logic [15:0]             rdata;
    logic [15:0]             tick;
    logic                    upd;
  } pim_state_s;

endpackage : pim_pkg

`default_nettype wire

// *** pim_ctl_model.sv ***
// Purpose: controller model that reads and writes the process images
// Assumes: register port sampled by the mapper on the rising edge
// Notes:   released address lines show the inverse of the last value; after a read the write data keep their old value
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// controller model
// ****************************************************************
module pim_ctl_model (
  // clock
  input  wire logic                        i_clk,
  // register port toward the mapper
  output logic [pim_pkg::ADDR_W-1:0]  o_addr,
  output logic [pim_pkg::DATA_W-1:0]  o_wdata,
  output logic                        o_wr,
  output logic                        o_rd
);
  // idle bus at time zero
  initial begin
    o_addr  = '0;
    o_wdata = '0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // one-cycle write, lines scrambled on release
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  // one-cycle read strobe, address scrambled on release; the read data are not sampled here
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
  endtask
endmodule // pim_ctl_model

`default_nettype wire

// *** test_io_process_image_mapper.sv ***
// Purpose: self-checking bench of the process image mapper
// Assumes: refresh period shortened to 8 cycles, periodic refresh off from the end of the reset test until the last test
// Notes:   reads queue their expectation; a monitor compares the cycle after
`timescale 1ns/100ps
`default_nettype none

module test_io_process_image_mapper;
  localparam int UPD = 8;
  logic                                   I_CLK_SYS;
  logic                                   I_RESET_N;
  logic [7:0]                             addr;
  logic [15:0]                            wdata;
  logic                                   wr;
  logic                                   rd_s;
  logic [15:0]                            rdata;
  logic                                   irq;
  pim_pkg::pim_fault_s                    fault;
  logic [7:0]                             din;
  logic [7:0]                             do8d;
  logic [7:0]                             do8c;
  logic [15:0]                            do16;
  pim_pkg::pim_ai_s [pim_pkg::NUM_AI-1:0] ai;
  pim_pkg::pim_ai_s [pim_pkg::NUM_AI-1:0] aiv;
  logic [pim_pkg::NUM_AI-1:0][7:0]        cfg;
  logic [23:0]                            f;
  logic [7:0]                             a;
  logic [15:0]                            rnd;
  logic [16:0]                            expq[$];
  logic [16:0]                            e;
  logic                                   rd_q;
  int                                     n_errors;
  int                                     checked;

  // ****************************************************************
  // clock, partner and design
  // ****************************************************************
  initial I_CLK_SYS = 1'b0;
  always #50 I_CLK_SYS = ~I_CLK_SYS;

  pim_ctl_model ctl (.i_clk(I_CLK_SYS), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd_s));

  pim_mapper #(.UPDATE_CYC(UPD)) DUT (
    .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd_s), .O_RDATA(rdata), .O_IRQ(irq), .I_FAULT(fault),
    .O_DO8_DIAG(do8d), .O_DO16(do16), .I_DIGITAL_INPUT_CHANNEL(din), .O_DO8_COMB(do8c),
    .I_AI(ai), .O_AI_CFG(cfg));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t read data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t pin %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] ad, input logic [15:0] ex);
    expq.push_back({1'b1, ex});
    ctl.rd(ad);
  endtask

  // read that only clears sticky bits, nothing expected
  task automatic rdx(input logic [7:0] ad);
    expq.push_back(17'h00000);
    ctl.rd(ad);
  endtask

  // field changes need two sync edges before a forced refresh sees them
  task automatic refresh();
    repeat (4) @(posedge I_CLK_SYS);
    ctl.wr(pim_pkg::ADR_CTRL, 16'h0002);
    repeat (3) @(negedge I_CLK_SYS);
  endtask

  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 20 && irq !== lvl; i++) @(negedge I_CLK_SYS);
    cmp_pin({15'h0, irq}, {15'h0, lvl});
    if (irq !== lvl) tally_and_finish();
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // read data monitor: valid only the cycle after the strobe
  // ****************************************************************
  always @(posedge I_CLK_SYS) rd_q <= rd_s;
  always @(negedge I_CLK_SYS) begin
    if (rd_q && expq.size() > 0) begin
      e = expq.pop_front();
      if (e[16]) cmp_rd(rdata, e[15:0]);
    end else if (I_RESET_N && rdata !== 16'h0000) begin
      cmp_rd(rdata, 16'h0000);
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    I_RESET_N = 1'b0;
    fault = '0;
    din = 8'h00;
    ai = '0;
    rnd = 16'h5514;
    n_errors = 0;
    checked = 0;
    repeat (5) @(posedge I_CLK_SYS);
    I_RESET_N <= 1'b1;
    @(negedge I_CLK_SYS);
    cmp_pin(do16, 16'h0000);
    rd(pim_pkg::ADR_CTRL, 16'h0001);
    rd(pim_pkg::ADR_IRQ_MASK, 16'h0000);
    rd(8'h7f, 16'h0000);
    ctl.wr(pim_pkg::ADR_CTRL, 16'h0000);
    $display("test reset done");
    // output drives of all three modules, read back too
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      a = pim_pkg::ADR_DO8D + 8'(k);
      ctl.wr(a, rnd);
      @(negedge I_CLK_SYS);
      cmp_pin(k == 0 ? {8'h0, do8d} : k == 1 ? do16 : {8'h0, do8c},
              k == 1 ? rnd : {8'h0, rnd[7:0]});
      rd(a, k == 1 ? rnd : {8'h0, rnd[7:0]});
    end
    $display("test drives done");
    // each fault kind alone, then all three, then clean
    for (int k = 0; k < 5; k++) begin
      rnd = lfsr(rnd);
      f = {(k == 0 || k == 3) ? rnd[7:0] : 8'h0, (k == 1 || k == 3) ? rnd[15:8] : 8'h0,
           (k == 2 || k == 3) ? rnd[11:4] : 8'h0};
      fault <= f;
      refresh();
      rd(pim_pkg::ADR_DIAG, {8'h0, f[23:16] | f[15:8] | f[7:0]});
    end
    $display("test faults done");
    // analog words, config bytes and combined inputs
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 4; j++) begin
        rnd = lfsr(rnd);
        aiv[j] = {rnd[15:8] ^ 8'h5a, rnd};
        ctl.wr(pim_pkg::ADR_AI_CFG0 + 8'(j), {rnd[7:0], rnd[15:8]});
      end
      @(negedge I_CLK_SYS);
      cmp_pin({8'h0, cfg[3]}, {8'h0, rnd[15:8]});
      // field inputs change on the rising edge
      @(posedge I_CLK_SYS);
      rnd = lfsr(rnd);
      ai <= aiv;
      din <= rnd[7:0];
      refresh();
      for (int j = 0; j < 4; j++) begin
        rd(pim_pkg::ADR_AI_MEAS + 8'(j), aiv[j][15:0]);
      end
      for (int j = 0; j < 4; j++) begin
        rd(pim_pkg::ADR_AI_CFG0 + 8'(j), {aiv[j][23:16], aiv[j][23:16] ^ 8'h5a});
      end
      rd(pim_pkg::ADR_DIN, {8'h0, rnd[7:0]});
    end
    $display("test analog done");
    // interrupt: masked, raised by a fault and by an input change, cleared by reading
    rdx(pim_pkg::ADR_IRQ_STAT);
    ctl.wr(pim_pkg::ADR_IRQ_MASK, 16'h0001);
    fault <= '0;
    refresh();
    refresh();
    rdx(pim_pkg::ADR_IRQ_STAT);
    refresh();
    cmp_pin({15'h0, irq}, 16'h0000);
    @(posedge I_CLK_SYS);
    fault <= 24'h010000;
    refresh();
    wait_irq(1'b1);
    rd(pim_pkg::ADR_IRQ_STAT, 16'h0005);
    wait_irq(1'b0);
    ctl.wr(pim_pkg::ADR_IRQ_MASK, 16'h0002);
    din <= ~rnd[7:0];
    refresh();
    wait_irq(1'b1);
    rd(pim_pkg::ADR_IRQ_STAT, 16'h0006);
    wait_irq(1'b0);
    $display("test interrupt done");
    // periodic refresh alone carries a field change into the image
    ctl.wr(pim_pkg::ADR_CTRL, 16'h0001);
    din <= rnd[7:0];
    repeat (UPD + 4) @(posedge I_CLK_SYS);
    rd(pim_pkg::ADR_DIN, {8'h0, rnd[7:0]});
    wait_irq(1'b1);
    $display("test periodic done");
    repeat (3) @(posedge I_CLK_SYS);
    tally_and_finish();
  end
endmodule // test_io_process_image_mapper

`default_nettype wire
